/* File: src/dot_matrix_pkg.sv */
// Purpose: shared constants and carriers for the dot matrix brightness controller
// Assumes: 50 MHz system clock
// Notes:   times are kept in ns, cycle counts derive from them
package dot_matrix_pkg;
  localparam int CLK_PERIOD_NS    = 20;
  localparam int SCAN_SLOT_NS     = 128000;
  localparam int SCAN_GAP_NS      = 8000;
  localparam int AUTO_RELEASE_NS  = 8000000;
  localparam int UNIT_SLOW_NS     = 210000000;
  localparam int UNIT_FAST_NS     = 70000000;
  localparam int PWM_STEPS        = 256;
  localparam int SCAN_SLOT_CYC    = SCAN_SLOT_NS / CLK_PERIOD_NS;
  localparam int SCAN_GAP_CYC     = (SCAN_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AUTO_RELEASE_CYC = AUTO_RELEASE_NS / CLK_PERIOD_NS;
  localparam int FINE_SLOW_CYC    = UNIT_SLOW_NS / (CLK_PERIOD_NS * PWM_STEPS);
  localparam int FINE_FAST_CYC    = UNIT_FAST_NS / (CLK_PERIOD_NS * PWM_STEPS);
  localparam int DETECT_FRAMES    = 2;
  localparam int NUM_LINES        = 12;
  localparam int NUM_SRC          = 16;
  localparam int NUM_DOTS         = 192;
  localparam int NUM_PROFILES     = 3;
  localparam int STAGE_BYTES      = 12;

  localparam logic [1:0] PAGE_ZERO  = 2'h0;
  localparam logic [1:0] PAGE_ONE   = 2'h1;
  localparam logic [1:0] PAGE_TWO   = 2'h2;
  localparam logic [1:0] PAGE_THREE = 2'h3;

  localparam logic [7:0] CFG_OFS      = 8'h00;
  localparam logic [7:0] GCC_OFS      = 8'h01;
  localparam logic [7:0] STAGE_FIRST  = 8'h02;
  localparam logic [7:0] STAGE_LAST   = 8'h0d;
  localparam logic [7:0] LATCH_OFS    = 8'h0e;
  localparam logic [7:0] PULLUP_OFS   = 8'h0f;
  localparam logic [7:0] PULLDOWN_OFS = 8'h10;
  localparam logic [7:0] ONOFF_LAST   = 8'h17;
  localparam logic [7:0] OPEN_FIRST   = 8'h18;
  localparam logic [7:0] OPEN_LAST    = 8'h2f;
  localparam logic [7:0] SHORT_FIRST  = 8'h30;
  localparam logic [7:0] SHORT_LAST   = 8'h47;
  localparam logic [7:0] DOT_LAST     = 8'hbf;
  localparam logic [7:0] MASK_OFS     = 8'hf0;
  localparam logic [7:0] FLAGS_OFS    = 8'hf1;

  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] LATCH_KEY = 8'h00;
  localparam int CFG_SSD  = 0;
  localparam int CFG_BEN  = 1;
  localparam int CFG_DET  = 2;
  localparam int CFG_DFS  = 4;
  localparam int CFG_SYNC = 6;
  localparam logic [1:0] SYNC_MASTER = 2'h1;
  localparam logic [1:0] SYNC_SLAVE  = 2'h2;
  localparam int IRQ_EVENTS = 5;
  localparam int IRQ_AUTO   = 7;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic [2:0] rise;
    logic [3:0] hold;
    logic [2:0] fall;
    logic [3:0] off;
    logic [1:0] lend;
    logic [1:0] lbegin;
    logic [3:0] lta;
    logic [7:0] ltb;
  } breath_cfg_t;

  typedef struct packed {
    logic [3:0] line;
    logic       active;
    logic [7:0] step;
    logic       frame;
    logic       slot_end;
  } scan_state_t;
endpackage : dot_matrix_pkg

/* File: src/scan_timer.sv */
// Purpose: scan line sequencer with duty step counter and frame sync
// Assumes: sync_in synchronous to clk_sys
// Notes:   SLOT_CYC must stay at or above 256
`timescale 1ns/1ps
module scan_timer import dot_matrix_pkg::*; #(
  parameter int SLOT_CYC = SCAN_SLOT_CYC,
  parameter int GAP_CYC  = SCAN_GAP_CYC
) (
  input  wire logic  clk_sys,
  input  wire logic  srst,
  input  wire logic  ce,
  input  wire logic  slave_mode,
  input  wire logic  sync_in,
  output scan_state_t scan
);
  localparam int STEP_DIV = SLOT_CYC / PWM_STEPS;
  logic [15:0] slot_cnt_r;
  logic [7:0]  div_cnt_r;
  logic [7:0]  step_r;
  logic [3:0]  line_r;
  logic        sync_prev_r;
  wire resync   = slave_mode && sync_in && !sync_prev_r;
  wire line_end = slot_cnt_r == 16'(SLOT_CYC + GAP_CYC - 1);
  wire last_ln  = line_r == 4'(NUM_LINES - 1);
  wire step_end = div_cnt_r == 8'(STEP_DIV - 1);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      slot_cnt_r  <= '0;
      div_cnt_r   <= '0;
      step_r      <= '0;
      line_r      <= '0;
      sync_prev_r <= 1'b0;
    end else if (ce) begin
      sync_prev_r <= sync_in;
      if (resync || line_end) begin
        slot_cnt_r <= '0;
        div_cnt_r  <= '0;
        step_r     <= '0;
        line_r     <= (resync || last_ln) ? 4'h0 : line_r + 4'h1;
      end else begin
        slot_cnt_r <= slot_cnt_r + 16'h1;
        div_cnt_r  <= step_end ? 8'h00 : div_cnt_r + 8'h01;
        if (step_end && step_r != 8'hff) step_r <= step_r + 8'h01;
      end
    end
  end

  assign scan.line     = line_r;
  assign scan.active   = slot_cnt_r < 16'(SLOT_CYC);
  assign scan.step     = step_r;
  assign scan.frame    = line_end && last_ln;
  assign scan.slot_end = slot_cnt_r == 16'(SLOT_CYC - 1);
endmodule : scan_timer

/* File: src/breath_profile.sv */
// Purpose: one self-running breathing profile (rise, hold, fall, off)
// Assumes: fine_tick is 1/256 of the breathing time unit
// Notes:   a rise or fall of code n lasts 256 << n fine ticks; hold or off of code n lasts 256 << (n-1), one fine tick for code 0 and codes 12 to 15
`timescale 1ns/1ps
module breath_profile import dot_matrix_pkg::*; (
  input  wire logic  clk_sys,
  input  wire logic  srst,
  input  wire logic  ce,
  input  wire logic  fine_tick,
  input  wire logic  restart,
  input  breath_cfg_t cfg,
  output logic [7:0] level,
  output logic       done
);
  typedef enum logic [1:0] {PH_RISE, PH_HOLD, PH_FALL, PH_OFF} phase_t;
  phase_t      phase_r;
  logic [17:0] cnt_r;
  logic [11:0] loops_r;
  logic        halted_r;
  logic        extra_r;
  logic [18:0] len;
  wire  [11:0] total = {cfg.lta, cfg.ltb};

  always_comb begin
    unique case (phase_r)
      PH_RISE: len = 19'h100 << cfg.rise;
      PH_HOLD: len = (cfg.hold == 4'h0) ? 19'h0 : 19'h100 << (cfg.hold - 4'h1);
      PH_FALL: len = 19'h100 << cfg.fall;
      PH_OFF:  len = (cfg.off == 4'h0) ? 19'h0 : 19'h100 << (cfg.off - 4'h1);
    endcase
  end

  wire last      = ({1'b0, cnt_r} + 19'h1) >= len;
  wire loop_hit  = phase_r == PH_FALL && total != 12'h0 && loops_r + 12'h1 == total && !extra_r;
  wire stop      = extra_r ? phase_r == PH_RISE : (loop_hit && cfg.lend == 2'h0);
  wire start_ext = loop_hit && cfg.lend != 2'h0;
  wire [7:0] rise_lvl = 8'(cnt_r >> cfg.rise);
  wire [7:0] fall_lvl = ~8'(cnt_r >> cfg.fall);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      phase_r  <= PH_RISE;
      cnt_r    <= '0;
      loops_r  <= '0;
      halted_r <= 1'b0;
      extra_r  <= 1'b0;
      done     <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (restart) begin
        phase_r  <= phase_t'(cfg.lbegin);
        cnt_r    <= '0;
        loops_r  <= '0;
        halted_r <= 1'b0;
        extra_r  <= 1'b0;
      end else if (fine_tick && !halted_r) begin
        cnt_r <= last ? 18'h0 : cnt_r + 18'h1;
        if (last) begin
          phase_r  <= stop ? phase_r : phase_t'(2'(phase_r) + 2'h1);
          loops_r  <= (phase_r == PH_FALL) ? loops_r + 12'h1 : loops_r;
          halted_r <= stop;
          done     <= stop;
          extra_r  <= extra_r || start_ext;
        end
      end
    end
  end

  assign level = halted_r ? (extra_r ? 8'hff : 8'h00) :
                 (phase_r == PH_RISE) ? rise_lvl :
                 (phase_r == PH_HOLD) ? 8'hff :
                 (phase_r == PH_FALL) ? fall_lvl : 8'h00;
endmodule : breath_profile

/* File: src/dot_matrix_ctrl.sv */
// Purpose: per-dot duty and breathing control of a scanned 12x16 matrix
// Assumes: host port and sense inputs synchronous to clk_sys
// Notes:   registers are paged; flags and mask answer on every page
// How it works
// - profile 00 or breathing off gives duty mode
// - eight-bit duty register per dot, 256 steps
// - enable bit starts breathing, clearing stops all
// - codes 01/10/11 pick profile one/two/three
// - profiles cycle rise, hold, fall, off
// - loops start anywhere, end on/off, counted
// - staged timing applies only after latch write
// - trigger rise captures faults over two frames
// - dots switched off keep their old results
// - one capture per trigger; host clears first
// - mask selects which events reach interrupt
// - unmasked event pulls interrupt low, sets flag
// - reading flags releases the interrupt
// - auto release after eight milliseconds low
// - release clears every flag bit
// - sync 01 drives frame clock out
// - sync 10 follows the incoming frame clock
// - sync 00/11 leaves pin undriven; resets 00
// - pull-up and pull-down selects for anti-ghosting
// - 128 us slot then 8 us gap per line
// - begin field picks starting phase
`timescale 1ns/1ps
module dot_matrix_ctrl import dot_matrix_pkg::*; #(
  parameter int SLOT_CYC    = SCAN_SLOT_CYC,
  parameter int AUTO_CYC    = AUTO_RELEASE_CYC,
  parameter int FINE_SLOW   = FINE_SLOW_CYC,
  parameter int FINE_FAST   = FINE_FAST_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        ce,
  input  host_req_t        host,
  output logic [7:0]       rdata,
  output logic             rvalid,
  input  wire logic [15:0] open_sense,
  input  wire logic [15:0] short_sense,
  output logic [15:0]      cs_drive,
  output logic [11:0]      sw_drive,
  output logic             nonoverlap_gap,
  output logic [7:0]       global_current_value,
  output logic [2:0]       pullup_sel,
  output logic [2:0]       pulldown_sel,
  output logic             duty_frequency_select,
  output logic             irq_out_n,
  input  wire logic        sync_i,
  output logic             sync_o,
  output logic             sync_oe
);
  logic [7:0]        duty_r [NUM_DOTS];
  logic [1:0]        prof_r [NUM_DOTS];
  logic [7:0]        stage_r [STAGE_BYTES];
  breath_cfg_t       live_r [NUM_PROFILES];
  breath_cfg_t       live_nxt [NUM_PROFILES];
  logic [NUM_DOTS-1:0] onoff_bits_r;
  logic [NUM_DOTS-1:0] open_bits_r;
  logic [NUM_DOTS-1:0] short_bits_r;
  logic [NUM_DOTS-1:0] open_nxt;
  logic [NUM_DOTS-1:0] short_nxt;
  logic [7:0]        cfg_r;
  logic [7:0]        gcc_r;
  logic [2:0]        pullup_r;
  logic [2:0]        pulldown_r;
  logic [7:0]        mask_r;
  logic [IRQ_EVENTS-1:0] flags_r;
  logic              irq_low_r;
  logic [19:0]       auto_cnt_r;
  logic [15:0]       fine_cnt_r;
  logic              latch_r;
  logic              det_prev_r;
  logic              det_busy_r;
  logic [1:0]        det_frames_r;
  logic [7:0]        rdata_r;
  logic              rvalid_r;
  logic [15:0]       cs_r;
  logic [11:0]       sw_r;
  logic              gap_r;
  logic [7:0]        level [NUM_PROFILES];
  logic [NUM_PROFILES-1:0] prof_done;
  logic [15:0]       cs_nxt;
  scan_state_t       scan;

  // host port decode
  wire [7:0] a        = host.addr;
  wire       hit_mask  = a == MASK_OFS;
  wire       hit_flags = a == FLAGS_OFS;
  wire       hit_glob  = hit_mask || hit_flags;
  wire       wr_p0     = host.wr && !hit_glob && host.page == PAGE_ZERO && a <= ONOFF_LAST;
  wire       wr_p1     = host.wr && !hit_glob && host.page == PAGE_ONE && a <= DOT_LAST;
  wire       wr_p2     = host.wr && !hit_glob && host.page == PAGE_TWO && a <= DOT_LAST;
  wire       wr_p3     = host.wr && !hit_glob && host.page == PAGE_THREE;
  wire       wr_stage  = wr_p3 && a >= STAGE_FIRST && a <= STAGE_LAST;
  wire       wr_latch  = wr_p3 && a == LATCH_OFS && host.wdata == LATCH_KEY;
  wire       wr_mask   = host.wr && hit_mask;
  wire [3:0] stage_ix  = 4'(a - STAGE_FIRST);
  wire [4:0] onoff_ix  = 5'(a);
  wire [4:0] open_ix   = 5'(a - OPEN_FIRST);
  wire [4:0] short_ix  = 5'(a - SHORT_FIRST);

  wire       ben    = cfg_r[CFG_BEN];
  wire       ssd    = cfg_r[CFG_SSD];
  wire [1:0] sync_mode = cfg_r[CFG_SYNC +: 2];

  // read selection
  wire [7:0] p0_rd = (a <= ONOFF_LAST) ? onoff_bits_r[8*onoff_ix +: 8] :
                     (a >= OPEN_FIRST && a <= OPEN_LAST) ? open_bits_r[8*open_ix +: 8] :
                     (a >= SHORT_FIRST && a <= SHORT_LAST) ? short_bits_r[8*short_ix +: 8] : 8'h00;
  wire [7:0] p3_rd = (a == CFG_OFS) ? cfg_r :
                     (a == GCC_OFS) ? gcc_r :
                     (a >= STAGE_FIRST && a <= STAGE_LAST) ? stage_r[stage_ix] :
                     (a == PULLUP_OFS) ? {5'h00, pullup_r} :
                     (a == PULLDOWN_OFS) ? {5'h00, pulldown_r} : 8'h00;
  wire [7:0] rd_mux = hit_mask ? mask_r :
                      hit_flags ? {3'h0, flags_r} :
                      (host.page == PAGE_ZERO) ? p0_rd :
                      (host.page == PAGE_ONE && a <= DOT_LAST) ? duty_r[a] :
                      (host.page == PAGE_TWO && a <= DOT_LAST) ? {6'h00, prof_r[a]} :
                      (host.page == PAGE_THREE) ? p3_rd : 8'h00;

  // breathing time base, shorter unit when the fast duty frequency is chosen
  wire [15:0] fine_top  = cfg_r[CFG_DFS] ? 16'(FINE_FAST - 1) : 16'(FINE_SLOW - 1);
  wire        fine_tick = fine_cnt_r >= fine_top;

  // profiles sit in reset while breathing is off so re-enabling starts clean
  for (genvar p = 0; p < NUM_PROFILES; p++) begin : g_prof
    assign live_nxt[p] = {stage_r[4*p][7:5], stage_r[4*p][4:1], stage_r[4*p+1][7:5],
                          stage_r[4*p+1][4:1], stage_r[4*p+2], stage_r[4*p+3]};
    breath_profile u_prof (
      .clk_sys   (clk_sys),
      .srst      (srst),
      .ce        (ce),
      .fine_tick (fine_tick),
      .restart   (latch_r || !ben),
      .cfg       (live_r[p]),
      .level     (level[p]),
      .done      (prof_done[p])
    );
  end

  scan_timer #(
    .SLOT_CYC (SLOT_CYC),
    .GAP_CYC  (SCAN_GAP_CYC)
  ) u_scan (
    .clk_sys    (clk_sys),
    .srst       (srst),
    .ce         (ce),
    .slave_mode (sync_mode == SYNC_SLAVE),
    .sync_in    (sync_i),
    .scan       (scan)
  );

  // dots of the line being scanned
  for (genvar x = 0; x < NUM_SRC; x++) begin : g_src
    wire [7:0] idx = {scan.line, 4'(x)};
    wire [1:0] sel = prof_r[idx];
    wire [7:0] eff = (ben && sel != 2'h0) ? level[2'(sel - 2'h1)] : duty_r[idx];
    assign cs_nxt[x] = scan.active && ssd && onoff_bits_r[idx] && scan.step < eff;
  end

  // fault capture at the end of each active slot while detection runs, only for dots switched on
  wire cap = det_busy_r && scan.slot_end;
  for (genvar d = 0; d < NUM_DOTS; d++) begin : g_dot
    wire take = cap && scan.line == 4'(d / NUM_SRC) && onoff_bits_r[d];
    assign open_nxt[d]  = take ? open_sense[d % NUM_SRC] : open_bits_r[d];
    assign short_nxt[d] = take ? short_sense[d % NUM_SRC] : short_bits_r[d];
  end

  wire det_rise   = cfg_r[CFG_DET] && !det_prev_r;
  wire det_finish = det_busy_r && scan.frame && det_frames_r == 2'(DETECT_FRAMES - 1);
  wire open_evt   = det_finish && |(open_bits_r & onoff_bits_r);
  wire short_evt  = det_finish && |(short_bits_r & onoff_bits_r);

  // interrupt: a fresh event in the release cycle keeps the line low
  wire [IRQ_EVENTS-1:0] events  = {prof_done, short_evt, open_evt};
  wire [IRQ_EVENTS-1:0] hits    = events & mask_r[IRQ_EVENTS-1:0];
  wire flag_read = host.rd && hit_flags;
  wire auto_due  = mask_r[IRQ_AUTO] && auto_cnt_r >= 20'(AUTO_CYC - 1);
  wire release_i = irq_low_r && (flag_read || auto_due);
  wire [IRQ_EVENTS-1:0] flags_nxt = (release_i ? '0 : flags_r) | hits;
  wire irq_low_nxt = (irq_low_r && !release_i) || |hits;

  wire [11:0] sw_nxt = scan.active ? 12'(12'h1 << scan.line) : 12'h000;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < NUM_DOTS; i++) begin
        duty_r[i] <= REG_RESET;
        prof_r[i] <= 2'h0;
      end
    end else if (ce) begin
      if (wr_p1) duty_r[a] <= host.wdata;
      if (wr_p2) prof_r[a] <= host.wdata[1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < STAGE_BYTES; i++) stage_r[i] <= REG_RESET;
      for (int p = 0; p < NUM_PROFILES; p++) live_r[p] <= '0;
      latch_r <= 1'b0;
    end else if (ce) begin
      if (wr_stage) stage_r[stage_ix] <= host.wdata;
      latch_r <= wr_latch;
      if (wr_latch) live_r <= live_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_r      <= CFG_RESET;
      gcc_r      <= REG_RESET;
      pullup_r   <= 3'h0;
      pulldown_r <= 3'h0;
      mask_r     <= REG_RESET;
      onoff_bits_r <= '0;
    end else if (ce) begin
      if (wr_p3 && a == CFG_OFS) cfg_r <= host.wdata;
      if (wr_p3 && a == GCC_OFS) gcc_r <= host.wdata;
      if (wr_p3 && a == PULLUP_OFS) pullup_r <= host.wdata[2:0];
      if (wr_p3 && a == PULLDOWN_OFS) pulldown_r <= host.wdata[2:0];
      if (wr_mask) mask_r <= host.wdata;
      if (wr_p0) onoff_bits_r[8*onoff_ix +: 8] <= host.wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      open_bits_r  <= '0;
      short_bits_r <= '0;
      det_prev_r   <= 1'b0;
      det_busy_r   <= 1'b0;
      det_frames_r <= 2'h0;
    end else if (ce) begin
      open_bits_r  <= open_nxt;
      short_bits_r <= short_nxt;
      det_prev_r   <= cfg_r[CFG_DET];
      if (det_rise) begin
        det_busy_r   <= 1'b1;
        det_frames_r <= 2'h0;
      end else if (det_finish) begin
        det_busy_r <= 1'b0;
      end else if (det_busy_r && scan.frame) begin
        det_frames_r <= det_frames_r + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flags_r    <= '0;
      irq_low_r  <= 1'b0;
      auto_cnt_r <= '0;
    end else if (ce) begin
      flags_r    <= flags_nxt;
      irq_low_r  <= irq_low_nxt;
      auto_cnt_r <= (irq_low_r && !release_i) ? auto_cnt_r + 20'h1 : 20'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      fine_cnt_r <= '0;
      rdata_r    <= '0;
      rvalid_r   <= 1'b0;
      cs_r       <= '0;
      sw_r       <= '0;
      gap_r      <= 1'b0;
    end else if (ce) begin
      fine_cnt_r <= fine_tick ? 16'h0 : fine_cnt_r + 16'h1;
      rvalid_r   <= host.rd;
      if (host.rd) rdata_r <= rd_mux;
      cs_r  <= cs_nxt;
      sw_r  <= sw_nxt;
      gap_r <= !scan.active;
    end
  end

  assign rdata                 = rdata_r;
  assign rvalid                = rvalid_r;
  assign cs_drive              = cs_r;
  assign sw_drive              = sw_r;
  assign nonoverlap_gap        = gap_r;
  assign global_current_value  = gcc_r;
  assign pullup_sel            = pullup_r;
  assign pulldown_sel          = pulldown_r;
  assign duty_frequency_select = cfg_r[CFG_DFS];
  assign irq_out_n             = !irq_low_r;
  // master marks each frame by holding the pin high through line 0
  assign sync_oe = sync_mode == SYNC_MASTER;
  assign sync_o  = sync_oe && scan.line == 4'h0;
endmodule : dot_matrix_ctrl

/* File: verif/dot_matrix_monitor.sv */
// Purpose: port checker for the dot matrix controller
// Assumes: ce high; mask and config tracked from host writes
// Notes:   a slot cut short by an incoming sync is not timed
`timescale 1ns/1ps
module dot_matrix_monitor import dot_matrix_pkg::*; #(
  parameter int SLOT_CYC = SCAN_SLOT_CYC,
  parameter int AUTO_CYC = AUTO_RELEASE_CYC
) (
  input wire logic        clk_sys,
  input wire logic        srst,
  input host_req_t        host,
  input wire logic        rvalid,
  input wire logic        irq_out_n,
  input wire logic [15:0] cs_drive,
  input wire logic [11:0] sw_drive,
  input wire logic        nonoverlap_gap,
  input wire logic        sync_i,
  input wire logic        sync_oe
);
  logic [7:0]  mask_r;
  logic [7:0]  cfg_r;
  logic [19:0] act_r;
  logic [19:0] low_r;
  logic        cut_r;
  wire         wr_mask = host.wr && host.addr == MASK_OFS;
  wire         wr_cfg  = host.wr && host.page == PAGE_THREE && host.addr == CFG_OFS;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mask_r <= '0;
      cfg_r  <= '0;
      act_r  <= '0;
      low_r  <= '0;
      cut_r  <= 1'b0;
    end else begin
      if (wr_mask) mask_r <= host.wdata;
      if (wr_cfg) cfg_r <= host.wdata;
      act_r <= (|sw_drive) ? act_r + 20'h1 : 20'h0;
      // release edge itself is not low, hence one cycle of slack below
      low_r <= irq_out_n ? 20'h0 : low_r + 20'h1;
      cut_r <= sync_i || (cut_r && |sw_drive);
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  read_answer_a: assert property (host.rd |=> rvalid) else $error("read got no answer");
  flag_release_a: assert property (host.rd && host.addr == FLAGS_OFS |=> irq_out_n)
    else $error("interrupt kept low after flag read");
  irq_cause_a: assert property ($fell(irq_out_n) |-> mask_r[4:0] != 5'h00)
    else $error("interrupt with every event masked");
  auto_release_a: assert property (mask_r[IRQ_AUTO] |-> low_r <= AUTO_CYC + 1)
    else $error("interrupt low past auto release time");
  sync_drive_a: assert property ($stable(cfg_r) |-> sync_oe == (cfg_r[CFG_SYNC+:2] == SYNC_MASTER))
    else $error("sync pin drive disagrees with mode");
  gap_dark_a: assert property (nonoverlap_gap |-> sw_drive == 12'h000 && cs_drive == 16'h0000)
    else $error("drive active during blanking gap");
  one_line_a: assert property ($onehot0(sw_drive)) else $error("two scan lines at once");
  slot_length_a: assert property ($fell(|sw_drive) && !cut_r |-> act_r == SLOT_CYC)
    else $error("scan slot length wrong");
endmodule : dot_matrix_monitor
bind dot_matrix_ctrl dot_matrix_monitor #(.SLOT_CYC(SLOT_CYC), .AUTO_CYC(AUTO_CYC)) u_monitor (
  .clk_sys(clk_sys), .srst(srst), .host(host), .rvalid(rvalid), .irq_out_n(irq_out_n),
  .cs_drive(cs_drive), .sw_drive(sw_drive), .nonoverlap_gap(nonoverlap_gap), .sync_i(sync_i),
  .sync_oe(sync_oe));

/* File: verif/host_mcu.sv */
// Purpose: host microcontroller model on the register port
// Assumes: requests launch 1 ns after a rising edge
// Notes:   released fields show inverted junk, never the old value
`timescale 1ns/1ps
module host_mcu import dot_matrix_pkg::*; (
  input  wire logic       clk_sys,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid,
  output host_req_t       req
);
  initial req = '0;
  task automatic wr(input logic [1:0] pg, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 req = '{1'b1, 1'b0, pg, a, d};
    @(posedge clk_sys);
    #1 req = '{1'b0, 1'b0, ~pg, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [1:0] pg, input logic [7:0] a, output logic [8:0] r);
    @(posedge clk_sys);
    #1 req = '{1'b0, 1'b1, pg, a, ~a};
    @(posedge clk_sys);
    #1 req = '{1'b0, 1'b0, ~pg, ~a, a};
    r = {rvalid, rdata};
  endtask : rd
endmodule : host_mcu

/* File: verif/dot_matrix_ctrl_bench.sv */
// Purpose: self-checking bench for the dot matrix controller
// Assumes: short slot, auto-release and breathing unit parameters
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module dot_matrix_ctrl_bench import dot_matrix_pkg::*; ;
  localparam int SLOT  = 512;
  localparam int AUTO  = 50;
  localparam int FRAME = NUM_LINES * (SLOT + SCAN_GAP_CYC);
  logic        clk_sys;
  logic        srst;
  logic        sync_i;
  host_req_t   host;
  logic [7:0]  rdata;
  logic [7:0]  gcv;
  logic        rvalid;
  logic        irq_out_n;
  logic        sync_oe;
  logic [15:0] open_sense;
  logic [15:0] cs_drive;
  logic [11:0] sw_drive;
  logic [2:0]  pu;
  logic [2:0]  pd;
  logic        so;
  logic        dfs;
  int          err_count;
  int          checked;
  int          c[3];
  logic [7:0]  duty[3] = '{8'h00, 8'h80, 8'hff};
  dot_matrix_ctrl #(.SLOT_CYC(SLOT), .AUTO_CYC(AUTO), .FINE_SLOW(2), .FINE_FAST(1)) dut (
    .clk_sys(clk_sys), .srst(srst), .ce(1'b1), .host(host), .rdata(rdata), .rvalid(rvalid),
    .open_sense(open_sense), .short_sense(open_sense & 16'h0001), .cs_drive(cs_drive), .sw_drive(sw_drive),
    .nonoverlap_gap(), .global_current_value(gcv), .pullup_sel(pu), .pulldown_sel(pd),
    .duty_frequency_select(dfs), .irq_out_n(irq_out_n), .sync_i(sync_i), .sync_o(so), .sync_oe(sync_oe));
  host_mcu h (.clk_sys(clk_sys), .rdata(rdata), .rvalid(rvalid), .req(host));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic pchk(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: pin %b not %b", $time, got, exp);
    end
  endtask : pchk
  task automatic rchk(input logic [1:0] pg, input logic [7:0] a, input logic [7:0] exp);
    logic [8:0] r;
    h.rd(pg, a, r);
    checked++;
    if (r !== {1'b1, exp}) begin
      err_count++;
      $display("mismatch at %0t: read %h at %h not %h", $time, r, a, exp);
    end
  endtask : rchk
  task automatic fw(input logic [7:0] a, input logic [7:0] d);
    h.wr(PAGE_THREE, a, d);
  endtask : fw
  task automatic wirq(input int n);
    for (int i = 0; i < n && irq_out_n !== 1'b0; i++) tick;
  endtask : wirq
  task automatic wsw(input int k);
    for (int i = 0; i < FRAME && sw_drive[k] !== 1'b1; i++) tick;
  endtask : wsw
  task automatic summarize;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  // the run needs about 70000 cycles
  initial begin
    #(99000 * 20);
    err_count++;
    summarize();
  end
  initial begin
    srst = 1'b1;
    sync_i = 1'b0;
    open_sense = 16'h0000;
    err_count = 0;
    checked = 0;
    repeat (16) @(posedge clk_sys);
    #1 srst = 1'b0;
    pchk(irq_out_n, 1'b1);
    pchk(sync_oe, 1'b0);
    rchk(PAGE_THREE, CFG_OFS, CFG_RESET);
    fw(8'h20, 8'h5a);
    rchk(PAGE_THREE, 8'h20, 8'h00);
    fw(GCC_OFS, 8'h01);
    fw(PULLUP_OFS, 8'h07);
    fw(PULLDOWN_OFS, 8'h01);
    pchk(gcv === 8'h01 && pu === 3'h7 && pd === 3'h1, 1'b1);
    for (int m = 0; m < 4; m++) begin
      fw(CFG_OFS, {m[1:0], 6'h11});
      rchk(PAGE_THREE, CFG_OFS, {m[1:0], 6'h11});
      pchk(sync_oe, m == 1);
      pchk(dfs, 1'b1);
    end
    $display("register and sync mode test done");
    fw(CFG_OFS, 8'h41);
    h.wr(PAGE_ZERO, 8'h00, 8'h07);
    for (int k = 0; k < 3; k++) h.wr(PAGE_ONE, k[7:0], duty[k]);
    wsw(1);
    pchk(so, 1'b0);
    wsw(0);
    pchk(so, 1'b1);
    c = '{0, 0, 0};
    repeat (SLOT) begin
      for (int k = 0; k < 3; k++) c[k] += int'(sw_drive[0] && cs_drive[k]);
      tick;
    end
    for (int k = 0; k < 3; k++) pchk(c[k] + 4 >= 2 * int'(duty[k]) && c[k] <= 2 * int'(duty[k]) + 4, 1'b1);
    $display("duty test done");
    h.wr(PAGE_TWO, 8'h00, 8'h01);
    fw(8'h05, 8'h01);
    fw(MASK_OFS, 8'h04);
    fw(CFG_OFS, 8'h03);
    repeat (3000) tick;
    pchk(irq_out_n, 1'b1);
    fw(LATCH_OFS, 8'h01);
    repeat (3000) tick;
    pchk(irq_out_n, 1'b1);
    rchk(PAGE_THREE, 8'h05, 8'h01);
    fw(LATCH_OFS, LATCH_KEY);
    // one rise plus one fall of 512 cycles each before the count ends
    repeat (950) tick;
    pchk(irq_out_n, 1'b1);
    wirq(200);
    pchk(irq_out_n, 1'b0);
    rchk(PAGE_ZERO, FLAGS_OFS, 8'h04);
    pchk(irq_out_n, 1'b1);
    rchk(PAGE_THREE, FLAGS_OFS, 8'h00);
    fw(8'h04, 8'h20);
    fw(MASK_OFS, 8'h84);
    fw(LATCH_OFS, LATCH_KEY);
    repeat (400) tick;
    pchk(irq_out_n, 1'b1);
    wirq(200);
    pchk(irq_out_n, 1'b0);
    repeat (AUTO + 2) tick;
    pchk(irq_out_n, 1'b1);
    rchk(PAGE_THREE, FLAGS_OFS, 8'h00);
    fw(8'h04, 8'h60);
    fw(MASK_OFS, 8'h00);
    fw(LATCH_OFS, LATCH_KEY);
    repeat (3000) tick;
    pchk(irq_out_n, 1'b1);
    rchk(PAGE_THREE, FLAGS_OFS, 8'h00);
    $display("breathing and interrupt test done");
    fw(MASK_OFS, 8'h01);
    h.wr(PAGE_ZERO, 8'h00, 8'h01);
    open_sense = 16'h0003;
    fw(CFG_OFS, 8'h03);
    fw(CFG_OFS, 8'h07);
    wirq(3 * FRAME);
    pchk(irq_out_n, 1'b0);
    rchk(PAGE_ZERO, OPEN_FIRST, 8'h01);
    rchk(PAGE_ZERO, SHORT_FIRST, 8'h01);
    rchk(PAGE_ZERO, FLAGS_OFS, 8'h01);
    repeat (2 * FRAME + 2000) tick;
    pchk(irq_out_n, 1'b1);
    $display("fault detect test done");
    wsw(5);
    fw(CFG_OFS, 8'h83);
    sync_i = 1'b1;
    tick;
    sync_i = 1'b0;
    repeat (4) tick;
    pchk(sw_drive === 12'h001, 1'b1);
    pchk(cs_drive[0], 1'b1);
    $display("slave sync test done");
    summarize();
  end
endmodule : dot_matrix_ctrl_bench
